// ==== verilog/pic_ctrl.sv ====
// Purpose: interrupt flags, mask, enable, scan and entry
// Assumes: one-cycle strobes, inputs synchronous to clk
// Notes: entry writes two words, then jumps; program held
// Operation
// - test requests at each next-instruction read
// - adder overflow sets fault, 24/48 bit
// - quotient overflow sets divide fault
// - exponent beyond 2^10-1 sets fault
// - trapped decimal instruction sets fault
// - channel block end or disconnect interrupts
// - search/move completion during 71/72 interrupts
// - clock equals compare time interrupts
// - external lines held by their devices
// - console interrupt unmasked, cleared on recognition
// - adjacent request unmasked, cleared on recognition
// - mask set and clear instructions
// - mask bits 0-7 gate external, channels
// - bits 9,10,11 gate clock and faults
// - read mask into accumulator upper bits
// - recognition clears master enable
// - enable effective after one more instruction
// - scanner picks first active entry
// - fixed priority order, adjacent last
// - lower channel, then lower line wins
// - sense ignores mask, clears sensed faults
// - selective clear instruction with mask field
// - save address at 4, code at 5
// - octal condition codes per source
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl (
    input wire logic clk, // cpu clock, 40 MHz
    input wire logic rst_b, // master clear, synchronous, active low
    input wire logic ce, // clock enable, low freezes state
    input wire logic nir_cycle, // next_instruction_read_cycle recognition point
    input wire logic [14:0] prog_addr, // program address counter, unexecuted
    input wire logic inst_valid, // instruction executed strobe
    input wire logic [23:0] inst_word, // instruction word with inst_valid
    input wire logic add_strobe, // adder result valid
    input wire logic add_double, // 48-bit precision add
    input wire logic add_subtract, // subtract operation
    input wire logic [47:0] add_a, // adder operand a
    input wire logic [47:0] add_b, // adder operand b
    input wire logic div_strobe, // divide start check
    input wire logic div_double, // 48-bit precision divide
    input wire logic [47:0] div_hi_mag, // dividend upper half magnitude
    input wire logic [47:0] div_divisor_mag, // divisor magnitude
    input wire logic exp_strobe, // trapped float exponent valid
    input wire logic [11:0] exp_result, // result exponent, two's complement
    input wire logic bcd_trap, // trapped decimal instruction executed
    input wire logic [3:0] chan_block_end, // channel reached end of block
    input wire logic [3:0] chan_eor, // channel got end-of-record disconnect
    input wire logic sm_done, // search or move finished
    input wire logic [5:0] sm_opcode, // opcode of the block operation
    input wire logic rtc_tick, // clock count updated
    input wire logic [23:0] rtc_count, // current clock count
    input wire logic [23:0] rtc_compare, // compare time from the register file
    input wire logic [31:0] ext_req, // external lines, channel*8+line
    input wire logic manual_sw, // console interrupt switch level
    input wire logic adj_req_in, // request pulse from adjacent computer
    output logic int_hold, // main program held for entry
    output logic mem_wr, // storage write strobe
    output logic [14:0] mem_addr, // storage write address
    output logic [23:0] mem_data, // storage write data
    output logic mem_low12, // write lower 12 bits only
    output logic jump_req, // transfer control to jump_addr
    output logic [14:0] jump_addr, // entry address
    output logic acc_load, // load accumulator upper bits
    output logic [23:0] acc_data, // accumulator image, mask in upper 12
    output logic sense_valid, // sense result strobe
    output logic sense_hit, // a selected condition was present
    output logic adj_req_out, // request pulse to adjacent computer
    output logic int_enabled // master enable currently in force
);
    // whole state of the block
    typedef struct packed {
        pic_pkg::pic_seq_t seq; // entry sequence
        logic [11:0] mask; // interrupt_gate_mask
        logic ie; // master enable
        logic ie_pend; // enable waiting one instruction
        pic_pkg::pic_int_t flags; // held interrupt flags
        logic sw_prev; // console switch last level
        logic [14:0] saved_pc; // captured at recognition
        logic [11:0] code; // captured condition code
        logic mem_wr; // output images
        logic [14:0] mem_addr;
        logic [23:0] mem_data;
        logic mem_low12;
        logic jump;
        logic acc_load;
        logic [23:0] acc_data;
        logic sense_valid;
        logic sense_hit;
        logic adj_out;
    } pic_state_t;

    pic_state_t st; // registered state
    pic_state_t next_st; // next state
    pic_pkg::pic_req_t raw; // all conditions present
    pic_pkg::pic_req_t gated; // conditions allowed to interrupt
    logic scan_any; // scanner found a request
    logic [11:0] scan_code; // scanner winner code

    // spread a 12-bit mask field over the requests
    function automatic pic_pkg::pic_req_t sel_vec(input logic [11:0] m, input logic unmasked);
        pic_pkg::pic_req_t v;
        v = '0;
        for (int c = 0; c < pic_pkg::NUM_CHAN; c++) begin
            for (int l = 0; l < pic_pkg::LINES_PER_CHAN; l++) begin
                v.ext[c * pic_pkg::LINES_PER_CHAN + l] = m[pic_pkg::MB_EXT_BASE + c];
            end
            v.int_f.chan[c] = m[pic_pkg::MB_CHAN_BASE + c];
        end
        v.int_f.srch = m[pic_pkg::MB_SRCH];
        v.int_f.rtc = m[pic_pkg::MB_RTC];
        v.int_f.expo = m[pic_pkg::MB_EXP_BCD];
        v.int_f.bcd = m[pic_pkg::MB_EXP_BCD];
        v.int_f.arith = m[pic_pkg::MB_ARITH_DIV];
        v.int_f.divf = m[pic_pkg::MB_ARITH_DIV];
        v.int_f.man = unmasked;
        v.int_f.adj = unmasked;
        return v;
    endfunction : sel_vec

    // external lines are device-held levels, never latched here
    always_comb begin
        raw.int_f = st.flags;
        raw.ext = ext_req;
        gated = pic_pkg::pic_req_t'(raw & sel_vec(st.mask, 1'b1));
        if (!st.ie) gated = '0;
    end

    // priority scanner
    pic_scan u_scan (
        .req(gated),
        .any(scan_any),
        .code(scan_code)
    );

    // next-state logic
    always_comb begin
        logic [47:0] b_op; // adder operand b, inverted for subtract
        logic [48:0] add_sum; // adder sum with carry
        logic ovf; // adder overflow this cycle
        logic dvf; // quotient overflow this cycle
        logic [11:0] exp_mag; // exponent magnitude
        logic take; // recognition this cycle
        logic [11:0] low12; // low field of the instruction
        pic_pkg::pic_int_t set_v; // flag sets this cycle
        pic_pkg::pic_int_t clr_v; // flag clears this cycle
        pic_pkg::pic_req_t sel; // selection from the low field
        b_op = add_subtract ? ~add_b : add_b;
        add_sum = {1'b0, add_a} + {1'b0, b_op} + {48'h0, add_subtract};
        ovf = 1'b0;
        dvf = 1'b0;
        exp_mag = exp_result[11] ? (~exp_result + 12'h001) : exp_result;
        take = 1'b0;
        low12 = inst_word[11:0];
        set_v = '0;
        clr_v = '0;
        sel = sel_vec(low12, 1'b0);
        next_st = st;
        // strobes last one cycle
        next_st.mem_wr = 1'b0;
        next_st.mem_low12 = 1'b0;
        next_st.jump = 1'b0;
        next_st.acc_load = 1'b0;
        next_st.sense_valid = 1'b0;
        next_st.adj_out = 1'b0;

        // overflow: operand signs agree, sum sign differs
        if (add_double) begin
            ovf = (add_a[47] == b_op[47]) && (add_sum[47] != add_a[47]);
        end else begin
            ovf = (add_a[23] == b_op[23]) && (add_sum[23] != add_a[23]);
        end
        // quotient too wide once upper dividend reaches divisor
        if (div_double) begin
            dvf = div_hi_mag >= div_divisor_mag;
        end else begin
            dvf = div_hi_mag[23:0] >= div_divisor_mag[23:0];
        end
        set_v.arith = add_strobe && ovf;
        set_v.divf = div_strobe && dvf;
        set_v.expo = exp_strobe && (exp_mag > pic_pkg::EXP_LIMIT);
        set_v.bcd = bcd_trap;
        set_v.chan = chan_block_end | chan_eor;
        set_v.srch = sm_done && ((sm_opcode == pic_pkg::OPC_SEARCH) ||
                                 (sm_opcode == pic_pkg::OPC_MOVE));
        set_v.rtc = rtc_tick && (rtc_count == rtc_compare);
        // switch edge, so a held switch cannot retrigger
        set_v.man = manual_sw && !st.sw_prev;
        set_v.adj = adj_req_in;
        next_st.sw_prev = manual_sw;

        // recognition only between instructions and while idle
        if (st.seq == pic_pkg::SEQ_IDLE && nir_cycle && scan_any) begin
            take = 1'b1;
            next_st.saved_pc = prog_addr;
            next_st.code = scan_code;
            next_st.seq = pic_pkg::SEQ_SAVE_P;
            next_st.ie = 1'b0;
            next_st.ie_pend = 1'b0;
            if (scan_code == pic_pkg::CODE_MAN) clr_v.man = 1'b1;
            if (scan_code == pic_pkg::CODE_ADJ) clr_v.adj = 1'b1;
        end

        // instruction effects; sequencer issues none during entry
        if (inst_valid && !take) begin
            // pending enable matures on the next instruction
            if (st.ie_pend) begin
                next_st.ie = 1'b1;
                next_st.ie_pend = 1'b0;
            end
            if (inst_word[23:12] == pic_pkg::OP_ENABLE) begin
                next_st.ie_pend = 1'b1;
            end else if (inst_word[23:12] == pic_pkg::OP_DISABLE) begin
                next_st.ie = 1'b0;
                next_st.ie_pend = 1'b0;
            end else if (inst_word[23:12] == pic_pkg::OP_MASK_SET) begin
                next_st.mask = st.mask | low12;
            end else if (inst_word[23:12] == pic_pkg::OP_MASK_CLR) begin
                next_st.mask = st.mask & ~low12;
            end else if (inst_word[23:12] == pic_pkg::OP_INT_CLR) begin
                // flags selected by the mask field
                clr_v.chan = sel.int_f.chan;
                clr_v.srch = sel.int_f.srch;
                clr_v.rtc = sel.int_f.rtc;
                clr_v.arith = sel.int_f.arith;
                clr_v.divf = sel.int_f.divf;
                clr_v.expo = sel.int_f.expo;
                clr_v.bcd = sel.int_f.bcd;
            end else if (inst_word[23:12] == pic_pkg::OP_ADJ_SEND) begin
                next_st.adj_out = 1'b1;
            end else if (inst_word[23:15] == pic_pkg::OP_SENSE) begin
                // mask register plays no part in sensing
                next_st.sense_valid = 1'b1;
                next_st.sense_hit = |(raw & sel);
                // channel flags survive sensing, only clear drops them
                clr_v.arith = sel.int_f.arith;
                clr_v.divf = sel.int_f.divf;
                clr_v.expo = sel.int_f.expo;
                clr_v.bcd = sel.int_f.bcd;
                clr_v.rtc = sel.int_f.rtc;
                clr_v.srch = sel.int_f.srch;
            end else if (inst_word[23:15] == pic_pkg::OP_READ_MASK_A ||
                         inst_word[23:15] == pic_pkg::OP_READ_MASK_B) begin
                next_st.acc_load = 1'b1;
                next_st.acc_data = {st.mask, 12'h000};
            end
        end

        // a new event in the clearing cycle survives
        next_st.flags = pic_pkg::pic_int_t'((st.flags & ~clr_v) | set_v);

        // entry sequence: save address, write code, jump
        case (st.seq)
            pic_pkg::SEQ_SAVE_P: begin
                next_st.mem_wr = 1'b1;
                next_st.mem_addr = pic_pkg::ADDR_SAVE_P;
                next_st.mem_data = {9'h000, st.saved_pc};
                next_st.seq = pic_pkg::SEQ_SAVE_CODE;
            end
            pic_pkg::SEQ_SAVE_CODE: begin
                // upper twelve bits of the entry word are left alone
                next_st.mem_wr = 1'b1;
                next_st.mem_low12 = 1'b1;
                next_st.mem_addr = pic_pkg::ADDR_ENTRY;
                next_st.mem_data = {12'h000, st.code};
                next_st.seq = pic_pkg::SEQ_JUMP;
            end
            pic_pkg::SEQ_JUMP: begin
                next_st.jump = 1'b1;
                next_st.seq = pic_pkg::SEQ_IDLE;
            end
            pic_pkg::SEQ_IDLE: begin
                next_st.seq = next_st.seq; // leaves only on recognition
            end
            default: begin
                next_st.seq = pic_pkg::SEQ_IDLE;
            end
        endcase
    end

    // master clear clears flags, mask and enable
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st <= '0;
            st.seq <= pic_pkg::SEQ_IDLE;
            st.mask <= pic_pkg::MASK_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // outputs straight from state, jump_addr a constant
    assign int_hold = (st.seq != pic_pkg::SEQ_IDLE);
    assign mem_wr = st.mem_wr;
    assign mem_addr = st.mem_addr;
    assign mem_data = st.mem_data;
    assign mem_low12 = st.mem_low12;
    assign jump_req = st.jump;
    assign jump_addr = pic_pkg::ADDR_ENTRY;
    assign acc_load = st.acc_load;
    assign acc_data = st.acc_data;
    assign sense_valid = st.sense_valid;
    assign sense_hit = st.sense_hit;
    assign adj_req_out = st.adj_out;
    assign int_enabled = st.ie;
endmodule : pic_ctrl
`default_nettype wire

// ==== verilog/pic_pkg.sv ====
// Purpose: constants and types for the interrupt control
// Assumes: 24-bit instruction words, 15-bit storage addresses, octal opcodes
// Notes: codes and addresses are hex forms of octal
package pic_pkg;
    // upper-twelve-bit opcodes (octal 7752, 7753, 7750, 7757)
    localparam logic [11:0] OP_MASK_SET = 12'hFEA; // selective mask set
    localparam logic [11:0] OP_MASK_CLR = 12'hFEB; // selective mask clear
    localparam logic [11:0] OP_INT_CLR = 12'hFE8; // selective interrupt clear
    localparam logic [11:0] OP_ADJ_SEND = 12'hFEF; // interrupt the neighbour
    localparam logic [11:0] OP_ENABLE = 12'hFFC; // octal 7774
    localparam logic [11:0] OP_DISABLE = 12'hFFB; // octal 7773
    // upper-nine-bit opcodes, digit c follows (octal 774, 772, 773)
    localparam logic [8:0] OP_SENSE = 9'h1FC; // sense selected conditions
    localparam logic [8:0] OP_READ_MASK_A = 9'h1FA; // read mask, first form
    localparam logic [8:0] OP_READ_MASK_B = 9'h1FB; // read mask, second form
    // entry locations
    localparam logic [14:0] ADDR_SAVE_P = 15'h0004; // unexecuted address
    localparam logic [14:0] ADDR_ENTRY = 15'h0005; // code word and entry point
    // condition codes (octal 0100+C, 0110..0117), external is 00LC
    localparam logic [11:0] CODE_CHAN_BASE = 12'h040;
    localparam logic [11:0] CODE_RTC = 12'h048;
    localparam logic [11:0] CODE_ARITH = 12'h049;
    localparam logic [11:0] CODE_DIV = 12'h04A;
    localparam logic [11:0] CODE_EXP = 12'h04B;
    localparam logic [11:0] CODE_BCD = 12'h04C;
    localparam logic [11:0] CODE_SRCH = 12'h04D;
    localparam logic [11:0] CODE_MAN = 12'h04E;
    localparam logic [11:0] CODE_ADJ = 12'h04F;
    // mask bit positions
    localparam int MB_EXT_BASE = 0; // bits 0..3 external, by channel
    localparam int MB_CHAN_BASE = 4; // bits 4..7 channel interrupts
    localparam int MB_SRCH = 8;
    localparam int MB_RTC = 9;
    localparam int MB_EXP_BCD = 10;
    localparam int MB_ARITH_DIV = 11;
    localparam logic [11:0] MASK_RESET = 12'h000; // all masked after master clear
    // fault limits and opcodes
    localparam logic [11:0] EXP_LIMIT = 12'h3FF; // 2^10-1
    localparam logic [5:0] OPC_SEARCH = 6'h39; // octal 71
    localparam logic [5:0] OPC_MOVE = 6'h3A; // octal 72
    localparam int NUM_CHAN = 4;
    localparam int LINES_PER_CHAN = 8;
    localparam int NUM_EXT = 32;

    // internally held interrupt flags
    typedef struct packed {
        logic arith; // arithmetic overflow fault
        logic divf; // divide fault
        logic expo; // exponent overflow or underflow fault
        logic bcd; // decimal fault
        logic [3:0] chan; // channel end-of-block or end-of-record
        logic srch; // search/move completion
        logic rtc; // real-time clock compare
        logic man; // console switch
        logic adj; // adjacent computer
    } pic_int_t;

    // everything the scanner looks at
    typedef struct packed {
        pic_int_t int_f; // held flags
        logic [31:0] ext; // external lines, index channel*8+line
    } pic_req_t;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAVE_P, SEQ_SAVE_CODE, SEQ_JUMP} pic_seq_t;
endpackage : pic_pkg

// ==== verilog/pic_scan.sv ====
// Purpose: priority scanner, winner and its code
// Assumes: requests already gated by mask and enable
// Notes: combinational, settles within one clock
`timescale 1ns/1ps
`default_nettype none
module pic_scan (
    input wire pic_pkg::pic_req_t req, // gated requests
    output logic any, // some request active
    output logic [11:0] code // condition code of the winner
);
    logic [11:0] ext_code [pic_pkg::NUM_EXT]; // per-line code table

    // external codes 00LC built per line
    genvar gi;
    generate
        for (gi = 0; gi < pic_pkg::NUM_EXT; gi++) begin : g_ext
            assign ext_code[gi] = {6'h00, 3'(gi % pic_pkg::LINES_PER_CHAN),
                                   3'(gi / pic_pkg::LINES_PER_CHAN)};
        end
    endgenerate

    // lowest level first, higher levels override
    always_comb begin
        any = |req;
        code = 12'h000;
        if (req.int_f.adj) code = pic_pkg::CODE_ADJ;
        if (req.int_f.man) code = pic_pkg::CODE_MAN;
        if (req.int_f.rtc) code = pic_pkg::CODE_RTC;
        if (req.int_f.srch) code = pic_pkg::CODE_SRCH;
        // lower channel wins
        for (int c = pic_pkg::NUM_CHAN - 1; c >= 0; c--) begin
            if (req.int_f.chan[c]) code = pic_pkg::CODE_CHAN_BASE | 12'(c);
        end
        // channel-major, line 0 of channel 0 first
        for (int e = pic_pkg::NUM_EXT - 1; e >= 0; e--) begin
            if (req.ext[e]) code = ext_code[e];
        end
        if (req.int_f.bcd) code = pic_pkg::CODE_BCD;
        if (req.int_f.expo) code = pic_pkg::CODE_EXP;
        if (req.int_f.divf) code = pic_pkg::CODE_DIV;
        if (req.int_f.arith) code = pic_pkg::CODE_ARITH;
    end
endmodule : pic_scan
`default_nettype wire

// ==== testbench/pic_ctrl_sva.sv ====
// Purpose: port checker for pic_ctrl
// Assumes: one clock domain, bound onto pic_ctrl
// Notes: timing here, data in the bench
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl_sva (
    input wire logic clk, // cpu clock
    input wire logic rst_b, // master clear, active low
    input wire logic ce, // clock enable
    input wire logic nir_cycle, // recognition point
    input wire logic inst_valid, // instruction strobe
    input wire logic [23:0] inst_word, // instruction word
    input wire logic int_hold, // entry running
    input wire logic mem_wr, // storage write
    input wire logic [14:0] mem_addr, // storage address
    input wire logic jump_req, // transfer request
    input wire logic [14:0] jump_addr, // entry address
    input wire logic sense_valid, // sense strobe
    input wire logic adj_req_out, // request to the neighbour
    input wire logic int_enabled // master enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // instructions the block surely takes
    wire logic inst_ok = inst_valid && ce && !nir_cycle && !int_hold;
    wire logic sense_op = inst_word[23:15] == pic_pkg::OP_SENSE; // sense family
    property p_entry_len; $rose(int_hold) |-> int_hold[*3] ##1 !int_hold; endproperty
    a_entry_len: assert property (p_entry_len) else $error("entry hold length wrong");
    property p_entry_cause;
        $rose(int_hold) |-> $past(nir_cycle) && $past(int_enabled) && !int_enabled;
    endproperty
    a_entry_cause: assert property (p_entry_cause) else $error("entry without cause");
    property p_entry_writes;
        $rose(int_hold) |-> ##1 mem_wr && mem_addr == pic_pkg::ADDR_SAVE_P
            ##1 mem_wr && mem_addr == pic_pkg::ADDR_ENTRY ##1 jump_req;
    endproperty
    a_entry_writes: assert property (p_entry_writes) else $error("entry walk wrong");
    property p_jump_addr; jump_addr == pic_pkg::ADDR_ENTRY; endproperty
    a_jump_addr: assert property (p_jump_addr) else $error("jump address wrong");
    property p_wr_held; mem_wr |-> int_hold; endproperty
    a_wr_held: assert property (p_wr_held) else $error("write outside entry");
    property p_disable; inst_ok && inst_word[23:12] == pic_pkg::OP_DISABLE |=> !int_enabled; endproperty
    a_disable: assert property (p_disable) else $error("disable ignored");
    property p_enable_late; $rose(int_enabled) |-> $past(inst_valid); endproperty
    a_enable_late: assert property (p_enable_late) else $error("enable too early");
    property p_adj_send; inst_ok && inst_word[23:12] == pic_pkg::OP_ADJ_SEND |=> adj_req_out; endproperty
    a_adj_send: assert property (p_adj_send) else $error("adjacent request missing");
    property p_sense_src; $rose(sense_valid) |-> $past(inst_valid) && $past(sense_op); endproperty
    a_sense_src: assert property (p_sense_src) else $error("sense without instruction");
endmodule : pic_ctrl_sva
bind pic_ctrl pic_ctrl_sva u_pic_ctrl_sva (.clk(clk), .rst_b(rst_b), .ce(ce),
    .nir_cycle(nir_cycle), .inst_valid(inst_valid), .inst_word(inst_word), .int_hold(int_hold),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .jump_req(jump_req), .jump_addr(jump_addr),
    .sense_valid(sense_valid), .adj_req_out(adj_req_out), .int_enabled(int_enabled));
`default_nettype wire

// ==== testbench/pic_ext_dev.sv ====
// Purpose: devices holding the external request lines
// Assumes: raise and drop set by the bench
// Notes: a line stays up until its device is told to drop it
`timescale 1ns/1ps
`default_nettype none
module pic_ext_dev (
    input wire logic clk, // cpu clock
    input wire logic rst_b, // master clear
    input wire logic [31:0] raise, // devices asserting a request
    input wire logic [31:0] drop, // devices told to release
    output logic [31:0] ext_req // held request lines
);
    // held level, drop wins so a cleared device never lingers
    always_ff @(posedge clk) begin
        ext_req <= rst_b ? ((ext_req | raise) & ~drop) : 32'h0000_0000;
    end
endmodule : pic_ext_dev
`default_nettype wire

// ==== testbench/pic_ctrl_tb.sv ====
// Purpose: self-checking bench for pic_ctrl
// Assumes: ce high; inputs change at the falling edge
// Notes: one falling edge per entry cycle
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl_tb;
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, nir_cycle = 1'b0, inst_valid = 1'b0; // control
    logic add_strobe = 1'b0, div_strobe = 1'b0, exp_strobe = 1'b0, bcd_trap = 1'b0; // events
    logic sm_done = 1'b0, rtc_tick = 1'b0, manual_sw = 1'b0, adj_req_in = 1'b0; // events
    logic add_double = 1'b0, add_subtract = 1'b0, div_double = 1'b0; // single precision only
    logic [14:0] prog_addr = 15'h0000, mem_addr, jump_addr; // addresses
    logic [23:0] inst_word = 24'h000000, rtc_count = 24'h000000, rtc_compare = 24'h000000;
    logic [47:0] add_a = 48'h0, add_b = 48'h0, div_hi_mag = 48'h0, div_divisor_mag = 48'h1;
    logic [11:0] exp_result = 12'h000; // float exponent
    logic [5:0] sm_opcode = 6'h00; // block operation
    logic [3:0] chan_block_end = 4'h0, chan_eor = 4'h0; // channel pulses
    logic [31:0] dev_raise = 32'h0, dev_drop = 32'h0, ext_req; // device lines
    logic int_hold, mem_wr, mem_low12, jump_req, acc_load, sense_valid, sense_hit; // outputs
    logic adj_req_out, int_enabled; // outputs
    logic [23:0] mem_data, acc_data; // outputs
    int n_fail = 0, checks = 0; // tallies
    logic [11:0] sel_of [6] = '{12'h800, 12'h800, 12'h400, 12'h400, 12'h100, 12'h200};
    pic_ext_dev u_pic_ext_dev (.clk(clk), .rst_b(rst_b), .raise(dev_raise), .drop(dev_drop),
        .ext_req(ext_req));
    pic_ctrl u_pic_ctrl (.*);
    initial begin // 40 MHz
        forever #12.5 clk = ~clk;
    end
    task automatic cyc;
        @(negedge clk);
    endtask : cyc
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // idle cycle first: no two strobes in one time step
    task automatic ins(input logic [11:0] op, input logic [11:0] sel);
        cyc;
        inst_word = {op, sel};
        inst_valid = 1'b1;
        cyc;
        inst_valid = 1'b0;
    endtask : ins
    task automatic rd_mask(input logic [11:0] m);
        ins({pic_pkg::OP_READ_MASK_A, 3'b000}, 12'h000);
        chk("mask", {8'h01, m, 12'h000}, {7'h00, acc_load, acc_data});
    endtask : rd_mask
    task automatic sense(input logic [11:0] sel, input logic hit);
        ins({pic_pkg::OP_SENSE, 3'b000}, sel);
        chk("sense", 32'({1'b1, hit}), 32'({sense_valid, sense_hit}));
    endtask : sense
    task automatic en;
        ins(pic_pkg::OP_ENABLE, 12'h000);
        chk("enable early", 32'h0, 32'(int_enabled));
        ins(12'h000, 12'h000);
        chk("enable late", 32'h1, 32'(int_enabled));
    endtask : en
    task automatic nir(input logic [14:0] p);
        cyc;
        nir_cycle = 1'b1;
        prog_addr = p;
        cyc;
        nir_cycle = 1'b0;
    endtask : nir
    task automatic recog(input logic [14:0] p, input logic [11:0] code);
        nir(p);
        chk("hold", 32'h2, 32'({int_hold, int_enabled}));
        cyc;
        chk("save", {2'b01, pic_pkg::ADDR_SAVE_P, p}, {1'b0, mem_wr, mem_addr, mem_data[14:0]});
        cyc;
        chk("code", {2'b11, pic_pkg::ADDR_ENTRY, 3'b000, code},
            {mem_wr, mem_low12, mem_addr, mem_data[14:0]});
        cyc;
        chk("jump", 32'h2, 32'({jump_req, int_hold}));
    endtask : recog
    // one internal event per kind
    task automatic ev(input int k);
        case (k)
            0: {add_a, add_b, add_strobe} = {48'h7FFFFF, 48'h1, 1'b1};
            1: {div_hi_mag, div_divisor_mag, div_strobe} = {48'h5, 48'h3, 1'b1};
            2: {exp_result, exp_strobe} = {12'h400, 1'b1};
            3: bcd_trap = 1'b1;
            4: {sm_opcode, sm_done} = {pic_pkg::OPC_SEARCH, 1'b1};
            default: {rtc_count, rtc_compare, rtc_tick} = {24'h00000A, 24'h00000A, 1'b1};
        endcase
        cyc;
        {add_strobe, div_strobe, exp_strobe, bcd_trap, sm_done, rtc_tick} = 6'h00;
    endtask : ev
    task automatic conclude;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude
    initial begin // run needs about 120 cycles
        repeat (4000) @(posedge clk);
        n_fail++;
        conclude;
    end
    initial begin
        repeat (12) cyc;
        rst_b = 1'b1;
        chk("enable after clear", 32'h0, 32'(int_enabled));
        rd_mask(12'h000);
        ins(pic_pkg::OP_MASK_SET, 12'hFFF);
        ins(pic_pkg::OP_MASK_CLR, 12'h0F0);
        rd_mask(12'hF0F);
        for (int k = 0; k < 6; k++) begin
            ev(k);
            sense(sel_of[k], 1'b1);
            sense(sel_of[k], 1'b0);
        end
        ev(0);
        en;
        recog(15'h1234, pic_pkg::CODE_ARITH);
        ins(pic_pkg::OP_INT_CLR, 12'h800);
        ins(pic_pkg::OP_MASK_SET, 12'h0F0);
        {dev_raise, chan_eor} = {32'h0420_0000, 4'h2}; // ch2 line5, ch3 line2
        cyc;
        {dev_raise, chan_eor} = {32'h0, 4'h0};
        en;
        recog(15'h0200, 12'h02A);
        ins(pic_pkg::OP_MASK_CLR, 12'h00C);
        en;
        recog(15'h0201, pic_pkg::CODE_CHAN_BASE + 12'h001);
        ins(pic_pkg::OP_INT_CLR, 12'h020);
        dev_drop = 32'h0420_0000;
        en;
        dev_drop = 32'h0;
        nir(15'h0202);
        chk("no entry", 32'h0, 32'(int_hold));
        manual_sw = 1'b1;
        recog(15'h0300, pic_pkg::CODE_MAN);
        en;
        nir(15'h0301);
        chk("manual cleared", 32'h0, 32'(int_hold));
        ins(pic_pkg::OP_ADJ_SEND, 12'h000);
        chk("adjacent out", 32'h1, 32'(adj_req_out));
        ins(pic_pkg::OP_MASK_CLR, 12'hFFF);
        adj_req_in = 1'b1;
        cyc;
        adj_req_in = 1'b0;
        recog(15'h0400, pic_pkg::CODE_ADJ);
        en;
        ins(pic_pkg::OP_DISABLE, 12'h000);
        chk("disabled", 32'h0, 32'(int_enabled));
        conclude;
    end
endmodule : pic_ctrl_tb
`default_nettype wire
